/* verilog/driver_diag_mux.sv */
`timescale 1ns/100ps
`include "diag_mux_params.svh"

// Behaviour
// - Sense enable low keeps the sense output undriven regardless of select.
// - With sense enabled, the select inputs choose the diagnostic quantity shown.
// - Quad parts decode three select bits; single and dual parts decode two.
// - Full logic offers current, temperature, supply; reduced offers current only.
// - Quad full: 000-011 channel currents, 100/110 temperature, 101/111 supply.
// - Dual full: 00 ch0, 01 ch1, 10 temperature, 11 supply; full single uses ch0 twice.
// - Off channel shows a failure flag for open load or short to supply.
// - Driven selected channel in power limitation raises the high flag level.
// - With clear held low, power limitation auto-restarts instead of latching.
// - A floating output reports open load on its selection.
// - A latched-off channel signals its latched state on its selection.
// - After unlatch a shorted driven channel restarts, then latches at threshold.
// - Clear held low for the latch reset time restarts all latched channels.
// - Latched flag shows only when enabled, driven high and selected.
module driver_diag_mux
	import diag_mux_pkg::*;
#(
	parameter int LATCH_RST_CYC = (`LATCH_RST_NS * `MCLK_MHZ + 999) / 1000
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic senseOutputEnable,
	input wire logic senseSelectBit0,
	input wire logic senseSelectBit1,
	input wire logic senseSelectBit2,
	input wire logic [3:0] channelDriveInput,
	input wire logic faultLatchClearN,
	input wire chanStatus_t channelStatus,
	output logic [3:0] channelPowerOutput,
	output senseOut_t diagnosticSenseOutput,
	output logic diagnosticSenseOutputOe
);

	localparam int PIN_W = `PIN_W;

	logic [PIN_W-1:0] pinRaw;
	logic [PIN_W-1:0] pinMeta_reg;
	logic [PIN_W-1:0] pinSync_reg;
	logic enSync;
	logic [2:0] selSync;
	logic [3:0] driveSync;
	logic clearNSync;
	chanStatus_t statSync;

	logic [31:0] config_reg;
	logic [1:0] chanCount;
	logic fullLogic;
	logic [3:0] chanMask;

	logic [15:0] clearCnt_reg;
	logic unlatchPulse;
	logic [3:0] latched_reg;
	logic [3:0] latched_next;
	logic [3:0] latchTrigger;
	logic [3:0] chanOn;

	senseOut_t sense_next;
	senseOut_t sense_reg;
	logic oe_reg;

	logic setupPhase;
	logic accessPhase;
	logic mapped;
	logic [31:0] status;
	logic [31:0] prdata_reg;
	logic slverr_reg;

	// Pins are asynchronous to mclk, so every one goes through two stages
	assign pinRaw = {senseOutputEnable, senseSelectBit2, senseSelectBit1,
		senseSelectBit0, channelDriveInput, faultLatchClearN, channelStatus};

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			pinMeta_reg <= '0;
			pinSync_reg <= '0;
		end else begin
			pinMeta_reg <= pinRaw;
			pinSync_reg <= pinMeta_reg;
		end
	end

	assign enSync = pinSync_reg[`PIN_EN_BIT];
	assign selSync = pinSync_reg[`PIN_SEL_MSB:`PIN_SEL_LSB];
	assign driveSync = pinSync_reg[`PIN_DRV_MSB:`PIN_DRV_LSB];
	assign clearNSync = pinSync_reg[`PIN_CLR_BIT];
	assign statSync = chanStatus_t'(pinSync_reg[`PIN_STAT_MSB:0]);

	// Variant configuration
	assign chanCount = config_reg[`CFG_COUNT_MSB:`CFG_COUNT_LSB];
	assign fullLogic = config_reg[`CFG_FULL_BIT];

	always_comb begin
		if (chanCount == `COUNT_ONE) begin
			chanMask = `MASK_ONE;
		end else if (chanCount == `COUNT_TWO) begin
			chanMask = `MASK_TWO;
		end else begin
			chanMask = `MASK_FOUR;
		end
	end

	// Clear held low long enough releases every latch; the count saturates
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			clearCnt_reg <= '0;
		end else if (clearNSync) begin
			clearCnt_reg <= '0;
		end else if (clearCnt_reg < 16'(LATCH_RST_CYC)) begin
			clearCnt_reg <= clearCnt_reg + 16'h0001;
		end
	end

	assign unlatchPulse = !clearNSync && (clearCnt_reg >= 16'(LATCH_RST_CYC));

	// Latching only happens with clear high; low clear means auto-restart
	always_comb begin
		latchTrigger = chanOn & {4{clearNSync}}
			& ((statSync.powerLimit & statSync.dynThr) | statSync.overTemp);
		// Set wins over the unlatch release
		latched_next = (latched_reg & ~{4{unlatchPulse}}) | latchTrigger;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			latched_reg <= '0;
		end else begin
			latched_reg <= latched_next & chanMask;
		end
	end

	// A driven channel stays on until it latches; after unlatch it retries
	assign chanOn = driveSync & chanMask & ~latched_reg;

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			channelPowerOutput <= '0;
		end else begin
			channelPowerOutput <= chanOn;
		end
	end

	// Select decode per channel count and logic variant
	always_comb begin
		sense_next.source = SRC_NONE;
		sense_next.channel = 2'h0;
		sense_next.faultFlag = 1'b0;
		if (chanCount != `COUNT_ONE && chanCount != `COUNT_TWO) begin
			// Quad parts decode all three select bits
			if (!selSync[2]) begin
				sense_next.source = SRC_CURRENT;
				sense_next.channel = selSync[1:0];
			end else if (fullLogic) begin
				sense_next.source = selSync[0] ? SRC_SUPPLY : SRC_TEMP;
			end
		end else if (selSync[1]) begin
			// Single and dual parts ignore the third select bit
			if (fullLogic) begin
				sense_next.source = selSync[0] ? SRC_SUPPLY : SRC_TEMP;
			end
		end else if (chanCount == `COUNT_TWO) begin
			sense_next.source = SRC_CURRENT;
			sense_next.channel = {1'b0, selSync[0]};
		end else if (fullLogic || !selSync[0]) begin
			// Reduced single parts only answer code 00
			sense_next.source = SRC_CURRENT;
		end
		if (sense_next.source == SRC_CURRENT) begin
			if (driveSync[sense_next.channel]) begin
				sense_next.faultFlag = latched_reg[sense_next.channel]
					| statSync.powerLimit[sense_next.channel];
			end else begin
				sense_next.faultFlag = statSync.openLoad[sense_next.channel]
					| statSync.shortSupply[sense_next.channel];
			end
		end
		if (!enSync) begin
			sense_next.source = SRC_NONE;
			sense_next.channel = 2'h0;
			sense_next.faultFlag = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sense_reg <= '0;
			oe_reg <= 1'b0;
		end else begin
			sense_reg <= sense_next;
			oe_reg <= enSync;
		end
	end

	assign diagnosticSenseOutput = sense_reg;
	assign diagnosticSenseOutputOe = oe_reg;

	// APB slave: read data is captured in setup, so no wait states are needed
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable;
	assign mapped = (paddr == `CONFIG_OFFSET) || (paddr == `STATUS_OFFSET);
	assign pready = 1'b1;
	assign pslverr = slverr_reg && accessPhase;
	assign prdata = prdata_reg;

	always_comb begin
		status = '0;
		status[`STAT_LATCH_MSB:`STAT_LATCH_LSB] = latched_reg;
		status[`STAT_ON_MSB:`STAT_ON_LSB] = channelPowerOutput;
		status[`STAT_FLAG_BIT] = sense_reg.faultFlag;
		status[`STAT_OE_BIT] = oe_reg;
		status[`STAT_CLEAR_BIT] = clearNSync;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prdata_reg <= '0;
			slverr_reg <= 1'b0;
		end else if (setupPhase) begin
			slverr_reg <= !mapped;
			if (pwrite || !mapped) begin
				prdata_reg <= '0;
			end else if (paddr == `CONFIG_OFFSET) begin
				prdata_reg <= config_reg;
			end else begin
				prdata_reg <= status;
			end
		end
	end

	// Only the variant fields are writable; other bits stay zero
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			config_reg <= `CFG_RESET;
		end else if (accessPhase && pwrite && paddr == `CONFIG_OFFSET) begin
			config_reg <= '0;
			config_reg[`CFG_COUNT_MSB:`CFG_COUNT_LSB] <= pwdata[`CFG_COUNT_MSB:`CFG_COUNT_LSB];
			config_reg[`CFG_FULL_BIT] <= pwdata[`CFG_FULL_BIT];
		end
	end

endmodule

/* verilog/diag_mux_params.svh */
`ifndef DIAG_MUX_PARAMS_SVH
`define DIAG_MUX_PARAMS_SVH

// Clock rate and fault latch reset time
`define MCLK_MHZ 250
`define LATCH_RST_NS 10000

// Register byte offsets
`define CONFIG_OFFSET 8'h00
`define STATUS_OFFSET 8'h04

// Configuration fields
`define CFG_COUNT_LSB 0
`define CFG_COUNT_MSB 1
`define CFG_FULL_BIT 2
`define CFG_RESET 32'h0000_0006

// Channel count codes
`define COUNT_ONE 2'h0
`define COUNT_TWO 2'h1

// Status fields
`define STAT_LATCH_LSB 0
`define STAT_LATCH_MSB 3
`define STAT_ON_LSB 4
`define STAT_ON_MSB 7
`define STAT_FLAG_BIT 8
`define STAT_OE_BIT 9
`define STAT_CLEAR_BIT 10

// Synchronised pin word layout
`define PIN_W 29
`define PIN_EN_BIT 28
`define PIN_SEL_MSB 27
`define PIN_SEL_LSB 25
`define PIN_DRV_MSB 24
`define PIN_DRV_LSB 21
`define PIN_CLR_BIT 20
`define PIN_STAT_MSB 19

// Channel masks per count
`define MASK_ONE 4'h1
`define MASK_TWO 4'h3
`define MASK_FOUR 4'hF

`endif

/* verilog/diag_mux_pkg.sv */
package diag_mux_pkg;

	typedef enum logic [1:0] {
		SRC_NONE = 2'h0,
		SRC_CURRENT = 2'h1,
		SRC_TEMP = 2'h2,
		SRC_SUPPLY = 2'h3
	} senseSource_t;

	typedef struct packed {
		senseSource_t source;
		logic [1:0] channel;
		logic faultFlag;
	} senseOut_t;

	typedef struct packed {
		logic [3:0] powerLimit;
		logic [3:0] overTemp;
		logic [3:0] openLoad;
		logic [3:0] shortSupply;
		logic [3:0] dynThr;
	} chanStatus_t;

endpackage

/* tb/driver_diag_mux_assertions.sv */
`timescale 1ns/100ps
module driver_diag_mux_assertions
	import diag_mux_pkg::*;
#(parameter int LATCH_RST_CYC = 2500) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic senseOutputEnable,
	input wire logic senseSelectBit0,
	input wire logic senseSelectBit1,
	input wire logic senseSelectBit2,
	input wire logic [3:0] channelDriveInput,
	input wire logic faultLatchClearN,
	input wire chanStatus_t channelStatus,
	input wire logic [3:0] channelPowerOutput,
	input wire senseOut_t diagnosticSenseOutput,
	input wire logic diagnosticSenseOutputOe
);
	logic [2:0] cfg;
	logic [2:0] sel;
	logic [1:0] ch;
	logic cur;
	int lowCnt;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	assign sel = {senseSelectBit2, senseSelectBit1, senseSelectBit0};
	assign ch = diagnosticSenseOutput.channel;
	assign cur = diagnosticSenseOutputOe && diagnosticSenseOutput.source == SRC_CURRENT;
	// Mirror of the variant word, so decode checks follow each reconfiguration
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			cfg <= 3'h6;
		else if (psel && penable && pwrite && paddr == 8'h00)
			cfg <= pwdata[2:0];
	// Saturates so a long blanking pulse cannot wrap the count
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			lowCnt <= 0;
		else
			lowCnt <= faultLatchClearN ? 0 : (lowCnt < 1000 ? lowCnt + 1 : lowCnt);
	function automatic logic [3:0] dec(input logic [2:0] c, input logic [2:0] s);
		if (c[1] && !s[2])
			return {SRC_CURRENT, s[1:0]};
		if (!c[1] && !s[1])
			return (c[2] || c[0] || !s[0]) ? {SRC_CURRENT, 1'b0, c[0] & s[0]} : 4'h0;
		return c[2] ? {s[0] ? SRC_SUPPLY : SRC_TEMP, 2'h0} : 4'h0;
	endfunction
	a_hiz_when_off: assert property (!$past(senseOutputEnable, 3) |-> !diagnosticSenseOutputOe)
		else $error("sense output driven while disabled");
	a_oe_when_on: assert property ($past(nrst, 3) && $past(senseOutputEnable, 3)
		|-> diagnosticSenseOutputOe) else $error("sense output not driven");
	a_quad_decode: assert property ($past(nrst, 3) && $past(senseOutputEnable, 3) && $past(cfg[1])
		|-> {diagnosticSenseOutput.source, cur ? ch : 2'h0} == dec($past(cfg), $past(sel, 3)))
		else $error("quad select decode wrong");
	a_dual_decode: assert property ($past(nrst, 3) && $past(senseOutputEnable, 3) && !$past(cfg[1])
		|-> {diagnosticSenseOutput.source, cur ? ch : 2'h0} == dec($past(cfg), $past(sel, 3)))
		else $error("two-bit select decode wrong");
	a_offstate_flag: assert property ($past(nrst, 3) && cur
		&& (($past(channelDriveInput, 3) >> ch) & 4'h1) == 4'h0
		|-> diagnosticSenseOutput.faultFlag == ((($past(channelStatus.openLoad
		| channelStatus.shortSupply, 3) >> ch) & 4'h1) != 4'h0)) else $error("off-state flag wrong");
	a_plimit_flag: assert property ($past(nrst, 3) && cur
		&& (($past(channelDriveInput & channelStatus.powerLimit, 3) >> ch) & 4'h1) != 4'h0
		|-> diagnosticSenseOutput.faultFlag) else $error("power limit flag missing");
	a_latched_off: assert property ($past(nrst, 5) && $past(faultLatchClearN
		& channelStatus.overTemp[0] & channelDriveInput[0], 5) |-> !channelPowerOutput[0])
		else $error("channel not latched off");
	a_clear_restart: assert property (lowCnt > LATCH_RST_CYC + 6
		&& $past(channelDriveInput[0], 3) |-> channelPowerOutput[0]) else $error("channel latched during clear");
endmodule
bind driver_diag_mux driver_diag_mux_assertions #(.LATCH_RST_CYC(LATCH_RST_CYC)) chk_u (
	.mclk(mclk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
	.pwdata(pwdata), .senseOutputEnable(senseOutputEnable), .senseSelectBit0(senseSelectBit0),
	.senseSelectBit1(senseSelectBit1), .senseSelectBit2(senseSelectBit2),
	.channelDriveInput(channelDriveInput), .faultLatchClearN(faultLatchClearN),
	.channelStatus(channelStatus), .channelPowerOutput(channelPowerOutput),
	.diagnosticSenseOutput(diagnosticSenseOutput), .diagnosticSenseOutputOe(diagnosticSenseOutputOe)
);

/* tb/fault_clear_mcu.sv */
`timescale 1ns/100ps
module fault_clear_mcu #(parameter int SLOT = 40, parameter int PULSE = 8) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [3:0] drive,
	output logic [2:0] sel,
	output logic clearN
);
	logic [7:0] tick, blank;
	logic [2:0] slot;
	logic [3:0] driveQ;
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst) begin
			tick <= 8'h00;
			slot <= 3'h0;
		end else if (tick == 8'(SLOT - 1)) begin
			tick <= 8'h00;
			slot <= (slot == 3'h5) ? 3'h0 : slot + 3'h1;
		end else
			tick <= tick + 8'h01;
	// Edge-triggered so a channel left on does not hold the line low
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst) begin
			driveQ <= 4'h0;
			blank <= 8'h00;
		end else begin
			driveQ <= drive;
			if (|(drive & ~driveQ))
				blank <= 8'(SLOT);
			else if (blank != 8'h00)
				blank <= blank - 8'h01;
		end
	assign sel = slot[2] ? {2'h2, slot[0]} : slot;
	assign clearN = !(blank != 8'h00 || (slot == 3'h0 && tick < 8'(PULSE)));
endmodule

/* tb/tb.sv */
`timescale 1ns/100ps
module tb
	import diag_mux_pkg::*;
;
	logic mclk, nrst, psel, penable, pwrite, pready, pslverr, en, clrTb, mcuRun, mcuClr, oe, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r, w;
	logic [2:0] selTb, mcuSel, sel;
	logic [3:0] drv, power;
	chanStatus_t st;
	senseOut_t so;
	int err_count, comparisons, seed, i, s;
	logic [2:0] cfgs [6] = '{3'h6, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0};
	assign sel = mcuRun ? mcuSel : selTb;
	always #2 mclk = ~mclk;
	driver_diag_mux #(.LATCH_RST_CYC(4)) dut_u (.mclk(mclk), .nrst(nrst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .senseOutputEnable(en), .senseSelectBit0(sel[0]),
		.senseSelectBit1(sel[1]), .senseSelectBit2(sel[2]), .channelDriveInput(drv),
		.faultLatchClearN(mcuRun ? mcuClr : clrTb), .channelStatus(st),
		.channelPowerOutput(power), .diagnosticSenseOutput(so), .diagnosticSenseOutputOe(oe));
	fault_clear_mcu mcu_u (.mclk(mclk), .nrst(nrst), .drive(drv), .sel(mcuSel), .clearN(mcuClr));
	function automatic logic [31:0] expCfg(input logic [31:0] wd);
		return wd & 32'h0000_0007;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
		@(posedge mclk);
		penable <= 1'b1;
		for (n = 0; n < 20; n++) begin
			@(posedge mclk);
			if (pready === 1'b1)
				break;
		end
		r = prdata;
		e = pslverr;
		{psel, penable} <= 2'h0;
		if (n == 20) begin
			err_count++;
			report_and_stop();
		end
	endtask
	initial begin
		{mclk, nrst, psel, penable, pwrite, paddr, pwdata, en, selTb, drv, mcuRun} = '0;
		{clrTb, st} = {1'b1, 20'h0};
		err_count = 0;
		comparisons = 0;
		seed = 75849;
		cyc(5);
		nrst <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h0000_0006);
		apb(1'b1, 8'h0C, 32'h1);
		chk({31'h0, e}, 32'h1);
		for (i = 0; i < 6; i++) begin
			en <= 1'b0;
			w = {$random(seed)};
			w[2:0] = cfgs[i];
			apb(1'b1, 8'h00, w);
			apb(1'b0, 8'h00, 32'h0);
			chk(r, expCfg(w));
			en <= 1'b1;
			for (s = 0; s < 8; s++) begin
				{selTb, drv, st} <= {3'(s), 24'($random(seed))};
				cyc(5);
			end
		end
		apb(1'b1, 8'h00, 32'h6);
		{drv, selTb, st, clrTb} <= {4'h4, 3'h2, 20'h0, 1'b0};
		cyc(12);
		chk({28'h0, power}, 32'h4);
		{clrTb, st.powerLimit, st.dynThr} <= {1'b1, 4'h4, 4'h4};
		cyc(8);
		chk({28'h0, power}, 32'h0);
		st <= '0;
		cyc(5);
		chk({31'h0, so.faultFlag}, 32'h1);
		selTb <= 3'h3;
		cyc(5);
		chk({31'h0, so.faultFlag}, 32'h0);
		{clrTb, st.powerLimit, st.dynThr} <= {1'b0, 4'h4, 4'h4};
		cyc(12);
		chk({28'h0, power}, 32'h4);
		clrTb <= 1'b1;
		cyc(8);
		chk({28'h0, power}, 32'h0);
		{st, drv, mcuRun} <= {20'h0, 4'h0, 1'b1};
		cyc(50);
		drv <= 4'h1;
		cyc(6);
		{st.powerLimit, st.dynThr} <= 8'h11;
		cyc(20);
		chk({28'h0, power}, 32'h1);
		st <= '0;
		cyc(300);
		chk({28'h0, power}, 32'h1);
		report_and_stop();
	end
endmodule
